// ### hw/dgt_channel.sv
// One timer channel: input sync, clock divider, prescaler, counter
`timescale 1ns/1ns
`default_nettype none
module dgt_channel
  import dgt_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic enable,
  input wire dgt_mode_t mode,
  input wire logic src_div16,
  input wire logic out_toggle,
  input wire logic out_en,
  input wire logic [1:0] edge_sel,
  input wire logic [7:0] prescale,
  input wire logic [15:0] ref_val,
  input wire logic event_pin,
  output logic [15:0] count,
  output logic [15:0] capture,
  output logic capture_evt,
  output logic compare_evt,
  output logic wave_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic sync1_r, sync2_r, sync3_r; // Pin synchroniser and edge history
  logic [3:0] div_r, div_nxt; // Divide-by-sixteen phase
  logic [7:0] pre_r, pre_nxt; // Prescaler phase
  logic [15:0] count_r, count_nxt; // Free-running counter
  logic [15:0] capt_r, capt_nxt; // Capture holding word
  logic wave_r, wave_nxt; // Output pin level, idles high
  logic src_tick, int_tick, qual_edge, tick, cap_hit, cmp_hit;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    div_nxt = div_r;
    pre_nxt = pre_r;
    int_tick = 1'b0;
    // Undivided source ticks every cycle
    src_tick = src_div16 ? (div_r == DGT_DIV16_LAST) : 1'b1;
    if (enable && src_div16)
    begin
      div_nxt = div_r + 4'h1;
    end
    // Greater-or-equal so a lowered prescale never overshoots
    if (enable && src_tick)
    begin
      if (pre_r >= prescale)
      begin
        pre_nxt = 8'h00;
        int_tick = 1'b1;
      end
      else
      begin
        pre_nxt = pre_r + 8'h01;
      end
    end
    // Only the second and third stages feed the edge detector
    qual_edge = (edge_sel[0] & sync2_r & ~sync3_r)
              | (edge_sel[1] & ~sync2_r & sync3_r);
    // Event mode counts edges, other running modes the prescaled clock
    if (mode == DGT_MODE_EVENT)
    begin
      tick = enable & qual_edge;
    end
    else
    begin
      tick = enable & int_tick & (mode != DGT_MODE_STOP);
    end
    // Natural 16-bit wrap from the maximum to zero
    count_nxt = tick ? count_r + 16'h0001 : count_r;
    cap_hit = enable & (mode == DGT_MODE_CAPTURE) & qual_edge;
    capt_nxt = cap_hit ? count_r : capt_r;
    // Match fires once, on the tick that reaches the reference
    cmp_hit = tick & (mode == DGT_MODE_COMPARE) & (count_nxt == ref_val);
    // Pulse mode returns high one cycle after going low
    wave_nxt = out_toggle ? wave_r : 1'b1;
    if (cmp_hit && out_en)
    begin
      wave_nxt = out_toggle ? ~wave_r : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      div_r <= 4'h0;
      pre_r <= 8'h00;
      count_r <= 16'h0000;
      capt_r <= 16'h0000;
      wave_r <= 1'b1;
    end
    else
    begin
      sync1_r <= event_pin;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      div_r <= div_nxt;
      pre_r <= pre_nxt;
      count_r <= count_nxt;
      capt_r <= capt_nxt;
      wave_r <= wave_nxt;
    end
  end

  assign count = count_r;
  assign capture = capt_r;
  assign capture_evt = cap_hit;
  assign compare_evt = cmp_hit;
  assign wave_out = wave_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  count_wrap_a: assert property (tick && count_r == DGT_COUNT_MAX |=> count_r == 16'h0000)
    else $error("counter did not wrap to zero");
  count_hold_a: assert property (!tick |=> count_r == $past(count_r))
    else $error("counter moved without a tick");
  capt_latch_a: assert property (cap_hit |=> capt_r == $past(count_r))
    else $error("capture word not the counter value");
  event_step_a: assert property (enable && mode == DGT_MODE_EVENT && qual_edge |=> count_r == $past(count_r) + 16'h0001)
    else $error("event did not advance counter");
  presc_gap_a: assert property (tick && mode == DGT_MODE_COMPARE && !src_div16 && prescale == 8'h01 ##1 enable && mode == DGT_MODE_COMPARE && prescale == 8'h01 |-> !tick)
    else $error("prescaler ticked back to back");
  div16_gap_a: assert property (enable && src_div16 && src_tick ##1 src_div16 |-> !src_tick)
    else $error("divided source ticked twice running");
  pulse_short_a: assert property (cmp_hit && out_en && !out_toggle ##1 !out_toggle && !(cmp_hit && out_en) |-> !wave_r ##1 wave_r)
    else $error("low pulse not one cycle");
  wave_toggle_a: assert property (cmp_hit && out_en && out_toggle |=> wave_r != $past(wave_r))
    else $error("output did not toggle");
  cmp_value_a: assert property (cmp_hit |=> count_r == $past(ref_val))
    else $error("match fired off the reference");

  wrap_c: cover property (tick && count_r == DGT_COUNT_MAX);
  capture_c: cover property (cap_hit);
  toggle_c: cover property (cmp_hit && out_en && out_toggle);

endmodule : dgt_channel
`default_nettype wire

// ### hw/dgt_pkg.sv
// Constants, register map and types of the dual general-purpose timer
// How it works
// - Two timers, free-running 16-bit up-counters
// - Capture mode latches counter on input edge
// - Compare match drives output, interrupt, or both
// - Event mode counts input edges, not clock
// - Programmable 8-bit prescaler sets count rate
// - Source is bus clock, divided by 1/16
// - Compare output pulses low or toggles level
package dgt_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets (APB, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] DGT_TIMER_SPAN = 8'h20; // Two timer blocks below
  localparam logic [3:0] DGT_CTRL_OFS = 4'h0; // Per-timer control
  localparam logic [3:0] DGT_REF_OFS = 4'h4; // Per-timer reference
  localparam logic [3:0] DGT_CAPT_OFS = 4'h8; // Per-timer capture hold
  localparam logic [3:0] DGT_COUNT_OFS = 4'hc; // Per-timer live count
  localparam logic [7:0] DGT_STAT_OFS = 8'h20; // Sticky event flags
  localparam logic [7:0] DGT_MASK_OFS = 8'h24; // Interrupt mask
  localparam int DGT_TIMER_SEL_BIT = 4; // Address bit picking timer

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int DGT_CTRL_EN_BIT = 0; // Counter enable
  localparam int DGT_CTRL_MODE_LO = 1; // Mode field [2:1]
  localparam int DGT_CTRL_DIV16_BIT = 3; // Source divide by sixteen
  localparam int DGT_CTRL_TOGGLE_BIT = 4; // Output toggles, else pulses
  localparam int DGT_CTRL_OUTEN_BIT = 5; // Compare drives output
  localparam int DGT_CTRL_IRQEN_BIT = 6; // Compare raises interrupt
  localparam int DGT_CTRL_EDGE_LO = 7; // Edge select [8:7]
  localparam int DGT_CTRL_PRE_LO = 16; // Prescaler [23:16]
  localparam logic [31:0] DGT_CTRL_WMASK = 32'h00ff_01ff; // Writable bits

  // ----------------------------------------------------------------
  // Status bit positions: per timer, capture then compare
  // ----------------------------------------------------------------
  localparam int DGT_STAT_CAPT_BIT = 0;
  localparam int DGT_STAT_CMP_BIT = 1;
  localparam int DGT_STAT_PER_TIMER = 2;

  // ----------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [31:0] DGT_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] DGT_REF_RST = 16'hffff;
  localparam logic [3:0] DGT_MASK_RST = 4'h0;
  localparam logic [3:0] DGT_DIV16_LAST = 4'hf; // Last phase of /16
  localparam logic [15:0] DGT_COUNT_MAX = 16'hffff; // Wrap point

  // Counting mode; 2'b10 parks the counter
  typedef enum logic [1:0] {
    DGT_MODE_CAPTURE = 2'b00,
    DGT_MODE_COMPARE = 2'b01,
    DGT_MODE_EVENT = 2'b11,
    DGT_MODE_STOP = 2'b10
  } dgt_mode_t;

endpackage : dgt_pkg

// ### hw/dgt_top.sv
// Dual general-purpose timer: APB register file, interrupts, channels
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module dgt_top
  import dgt_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic timer0_event_input,
  input wire logic timer1_event_input,
  output logic timer0_wave_output,
  output logic timer1_wave_output
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r [2]; // Per-timer control words
  logic [31:0] ctrl_nxt [2];
  logic [15:0] ref_r [2]; // Per-timer reference values
  logic [15:0] ref_nxt [2];
  logic [3:0] stat_r, stat_nxt; // Sticky event flags
  logic [3:0] mask_r, mask_nxt; // Interrupt enables, same layout
  logic [31:0] rdata_r, rdata_nxt; // Read word, loaded in setup

  // ----------------------------------------------------------------
  // Channel wiring
  // ----------------------------------------------------------------
  logic [15:0] cnt_w [2]; // Live counts
  logic [15:0] capt_w [2]; // Capture words
  logic [1:0] capt_evt_w; // Capture events, one-cycle pulses
  logic [1:0] cmp_evt_w; // Compare events, one-cycle pulses
  logic [1:0] wave_w; // Output pin levels
  logic [1:0] pin_w; // Raw input pins

  // ----------------------------------------------------------------
  // Decode wires
  // ----------------------------------------------------------------
  logic setup_ph; // First cycle of a transfer
  logic access_ph; // Completing cycle, pready is always high
  logic in_timer; // Address falls in a timer block
  logic tsel; // Which timer block
  logic addr_ok; // Mapped and word aligned
  logic [3:0] set_v; // Events arriving this cycle
  logic [3:0] clr_v; // Write-one-to-clear request
  logic [31:0] rd_val; // Selected read word

  assign pin_w = {timer1_event_input, timer0_event_input};
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign in_timer = paddr < DGT_TIMER_SPAN;
  assign tsel = paddr[DGT_TIMER_SEL_BIT];

  // ----------------------------------------------------------------
  // Address check and read selection
  // ----------------------------------------------------------------
  always_comb
  begin
    addr_ok = 1'b0;
    rd_val = 32'h0000_0000;
    // Misaligned words are refused rather than silently rounded down
    if (paddr[1:0] == 2'b00)
    begin
      if (in_timer)
      begin
        addr_ok = 1'b1;
        unique case (paddr[3:0])
          DGT_CTRL_OFS: rd_val = ctrl_r[tsel];
          DGT_REF_OFS: rd_val = {16'h0000, ref_r[tsel]};
          DGT_CAPT_OFS: rd_val = {16'h0000, capt_w[tsel]};
          DGT_COUNT_OFS: rd_val = {16'h0000, cnt_w[tsel]};
          default: addr_ok = 1'b0;
        endcase
      end
      else if (paddr == DGT_STAT_OFS)
      begin
        addr_ok = 1'b1;
        rd_val = {28'h0000000, stat_r};
      end
      else if (paddr == DGT_MASK_OFS)
      begin
        addr_ok = 1'b1;
        rd_val = {28'h0000000, mask_r};
      end
    end
  end

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    ref_nxt = ref_r;
    mask_nxt = mask_r;
    rdata_nxt = rdata_r;
    clr_v = 4'h0;
    // Read word is latched in setup so prdata leaves a flip-flop
    if (setup_ph && !pwrite)
    begin
      rdata_nxt = rd_val;
    end
    // Writes land only at the completing edge of a mapped access
    if (access_ph && pwrite && addr_ok)
    begin
      if (in_timer)
      begin
        if (paddr[3:0] == DGT_CTRL_OFS)
        begin
          ctrl_nxt[tsel] = pwdata & DGT_CTRL_WMASK;
        end
        if (paddr[3:0] == DGT_REF_OFS)
        begin
          ref_nxt[tsel] = pwdata[15:0];
        end
      end
      else if (paddr == DGT_STAT_OFS)
      begin
        clr_v = pwdata[3:0];
      end
      else
      begin
        mask_nxt = pwdata[3:0];
      end
    end
    // Capture always flags; compare flags only when asked to
    for (int i = 0; i < 2; i++)
    begin
      set_v[i * DGT_STAT_PER_TIMER + DGT_STAT_CAPT_BIT] = capt_evt_w[i];
      set_v[i * DGT_STAT_PER_TIMER + DGT_STAT_CMP_BIT] =
        cmp_evt_w[i] & ctrl_r[i][DGT_CTRL_IRQEN_BIT];
    end
    // A new event beats a clear in the same cycle
    stat_nxt = (stat_r & ~clr_v) | set_v;
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      ctrl_r[0] <= DGT_CTRL_RST;
      ctrl_r[1] <= DGT_CTRL_RST;
      ref_r[0] <= DGT_REF_RST;
      ref_r[1] <= DGT_REF_RST;
      stat_r <= 4'h0;
      mask_r <= DGT_MASK_RST;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      ref_r <= ref_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Bus answers and interrupt
  // ----------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access_ph & ~addr_ok;
  assign prdata = rdata_r;
  assign irq = |(stat_r & mask_r);

  // ----------------------------------------------------------------
  // Two identical channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++)
  begin : g_chan
    dgt_channel u_chan (
      .clock(clock),
      .sys_rst(sys_rst),
      .enable(ctrl_r[g][DGT_CTRL_EN_BIT]),
      .mode(dgt_mode_t'(ctrl_r[g][DGT_CTRL_MODE_LO +: 2])),
      .src_div16(ctrl_r[g][DGT_CTRL_DIV16_BIT]),
      .out_toggle(ctrl_r[g][DGT_CTRL_TOGGLE_BIT]),
      .out_en(ctrl_r[g][DGT_CTRL_OUTEN_BIT]),
      .edge_sel(ctrl_r[g][DGT_CTRL_EDGE_LO +: 2]),
      .prescale(ctrl_r[g][DGT_CTRL_PRE_LO +: 8]),
      .ref_val(ref_r[g]),
      .event_pin(pin_w[g]),
      .count(cnt_w[g]),
      .capture(capt_w[g]),
      .capture_evt(capt_evt_w[g]),
      .compare_evt(cmp_evt_w[g]),
      .wave_out(wave_w[g])
    );
  end

  assign timer0_wave_output = wave_w[0];
  assign timer1_wave_output = wave_w[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  stat_set_a: assert property (capt_evt_w[1] |=>
    stat_r[DGT_STAT_PER_TIMER + DGT_STAT_CAPT_BIT])
    else $error("capture event not flagged");
  cmp_flag_a: assert property (cmp_evt_w[1] && ctrl_r[1][DGT_CTRL_IRQEN_BIT] |=> stat_r[DGT_STAT_PER_TIMER + DGT_STAT_CMP_BIT] ##0 (mask_r[3] -> irq))
    else $error("compare did not raise request");
  cmp_quiet_a: assert property (!cmp_evt_w[0] && access_ph && pwrite && paddr == DGT_STAT_OFS && pwdata[1] && !capt_evt_w[0] |=> !stat_r[DGT_STAT_CMP_BIT])
    else $error("flag survived its clear");

  irq_c: cover property (irq);
  rd_c: cover property (access_ph && !pwrite && addr_ok);

endmodule : dgt_top
`default_nettype wire

// ### verif/dgt_event_model.sv
// Model of the outside logic that drives both timer input pins
`timescale 1ns/1ns
`default_nettype none
module dgt_event_model (
  input wire logic clock,
  output logic timer0_event_input,
  output logic timer1_event_input
);
  // Pin levels; both rest low between bursts
  logic [1:0] lvl_r;
  assign timer0_event_input = lvl_r[0];
  assign timer1_event_input = lvl_r[1];
  initial lvl_r = 2'h0;
  // ----------------------------------------------------------------
  // Burst of n pulses, each level held hold cycles
  // ----------------------------------------------------------------
  // Hold stays at two or more so the synchroniser sees it
  task pulse(input int ch, input int n, input int hold);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(posedge clock);
      lvl_r[ch] <= 1'b1;
      repeat (hold) @(posedge clock);
      lvl_r[ch] <= 1'b0;
      repeat (hold - 1) @(posedge clock);
    end
  endtask : pulse
endmodule : dgt_event_model
`default_nettype wire

// ### verif/dual_general_purpose_timer_tb_top.sv
// Self-checking testbench of the dual timer over APB
`timescale 1ns/1ns
`default_nettype none
module dual_general_purpose_timer_tb_top;
  import dgt_pkg::*;
  logic clock = 1'b0;
  logic sys_rst, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d, c1, c2;
  logic pready, pslverr, irq, e, ev0, ev1, w0, w1;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  always #5 clock = ~clock;
  dgt_top DUT (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .timer0_event_input(ev0), .timer1_event_input(ev1),
    .timer0_wave_output(w0), .timer1_wave_output(w1));
  dgt_event_model PART (.clock(clock), .timer0_event_input(ev0),
    .timer1_event_input(ev1));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      $display("ERROR %s expected %h seen %h", nm, x, s);
      miscompares++;
    end
  endtask : chk
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // One APB transfer; an edge passes first so release and setup never meet
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic er);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd, d, e);
  endtask : wr
  function automatic logic [7:0] ra(input logic t, input logic [3:0] o);
    ra = {3'h0, t, o};
  endfunction : ra
  // Control word with enable set; f[3:0] is irq, pin, toggle, /16
  function automatic logic [31:0] cv(input logic [1:0] m,
    input logic [4:0] f, input logic [1:0] ed, input logic [7:0] p);
    cv = {8'h00, p, 7'h00, ed, f[3:1], f[0], m, 1'b1};
  endfunction : cv
  function automatic logic [31:0] df(input logic [31:0] a, b);
    logic [15:0] t;
    t = a[15:0] - b[15:0];
    df = {16'h0000, t};
  endfunction : df
  // Burst of five pulses must advance the count by x
  task evrun(input logic t, input logic [31:0] c, input int x);
    wr(ra(t, DGT_CTRL_OFS), c);
    xfer(1'b0, ra(t, DGT_COUNT_OFS), 32'h0, c1, e);
    PART.pulse(t, 5, 3);
    repeat (6) @(posedge clock);
    xfer(1'b0, ra(t, DGT_COUNT_OFS), 32'h0, c2, e);
    chk("event count", df(c2, c1), x);
  endtask : evrun
  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    #900000;
    miscompares++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {sys_rst, psel, penable, pwrite} = 4'h8;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    xfer(1'b0, ra(0, DGT_REF_OFS), 32'h0, d, e);
    chk("ref reset", d, 32'h0000ffff);
    xfer(1'b0, ra(1, DGT_COUNT_OFS), 32'h0, d, e);
    chk("count reset", d, 32'h0);
    chk("wave1 idle", {31'h0, w1}, 32'h1);
    xfer(1'b0, 8'h30, 32'h0, d, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    xfer(1'b1, 8'h02, 32'h1, d, e);
    chk("misaligned err", {31'h0, e}, 32'h1);
    // Tick rate: P=1 gives 20 counts in 40 cycles
    wr(ra(0, DGT_CTRL_OFS), cv(2'b01, 5'h0, 2'h0, 8'h01));
    xfer(1'b0, ra(0, DGT_COUNT_OFS), 32'h0, c1, e);
    repeat (37) @(posedge clock);
    xfer(1'b0, ra(0, DGT_COUNT_OFS), 32'h0, c2, e);
    chk("prescale rate", df(c2, c1), 32'd20);
    // Source divided by sixteen: 10 counts in 160 cycles
    wr(ra(0, DGT_CTRL_OFS), cv(2'b01, 5'h1, 2'h0, 8'h00));
    xfer(1'b0, ra(0, DGT_COUNT_OFS), 32'h0, c1, e);
    repeat (157) @(posedge clock);
    xfer(1'b0, ra(0, DGT_COUNT_OFS), 32'h0, c2, e);
    chk("div16 rate", df(c2, c1), 32'd10);
    // Compare match: one-cycle low pulse, status, masked interrupt
    xfer(1'b0, ra(0, DGT_COUNT_OFS), 32'h0, c1, e);
    wr(ra(0, DGT_REF_OFS), c1 + 32'h20);
    wr(ra(0, DGT_CTRL_OFS), cv(2'b01, 5'hc, 2'h0, 8'h00));
    n = 0;
    while (w0 !== 1'b0 && n < 200)
    begin
      @(posedge clock);
      n++;
    end
    chk("wave low", {31'h0, w0}, 32'h0);
    @(posedge clock);
    chk("pulse width", {31'h0, w0}, 32'h1);
    xfer(1'b0, DGT_STAT_OFS, 32'h0, d, e);
    chk("cmp status", d, 32'h2);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(DGT_MASK_OFS, 32'h2);
    @(posedge clock);
    chk("irq on", {31'h0, irq}, 32'h1);
    wr(DGT_STAT_OFS, 32'h2);
    @(posedge clock);
    chk("irq clear", {31'h0, irq}, 32'h0);
    // Toggle: next match only after the counter wraps, 65536 ticks
    xfer(1'b0, ra(0, DGT_COUNT_OFS), 32'h0, c1, e);
    wr(ra(0, DGT_REF_OFS), c1 + 32'h20);
    wr(ra(0, DGT_CTRL_OFS), cv(2'b01, 5'h6, 2'h0, 8'h00));
    n = 0;
    while (w0 !== 1'b1 && n < 200)
    begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (w0 !== 1'b0 && n < 200)
    begin
      @(posedge clock);
      n++;
    end
    n = 0;
    while (w0 !== 1'b1 && n < 70000)
    begin
      @(posedge clock);
      n++;
    end
    chk("wrap period", n, 32'd65536);
    // Capture: two rising edges 60 cycles apart
    wr(ra(1, DGT_CTRL_OFS), cv(2'b00, 5'h0, 2'h1, 8'h00));
    fork
      PART.pulse(1, 2, 30);
      begin
        repeat (20) @(posedge clock);
        xfer(1'b0, ra(1, DGT_CAPT_OFS), 32'h0, c1, e);
      end
    join
    repeat (6) @(posedge clock);
    xfer(1'b0, ra(1, DGT_CAPT_OFS), 32'h0, c2, e);
    chk("capture gap", df(c2, c1), 32'd60);
    xfer(1'b0, DGT_STAT_OFS, 32'h0, d, e);
    chk("capt status", d & 32'h4, 32'h4);
    // Event counting with both, rising and no edges, then in stop mode
    evrun(1'b1, cv(2'b11, 5'h0, 2'h3, 8'h05), 10);
    evrun(1'b0, cv(2'b11, 5'h0, 2'h1, 8'h00), 5);
    evrun(1'b1, cv(2'b11, 5'h0, 2'h0, 8'h00), 0);
    evrun(1'b1, cv(2'b10, 5'h0, 2'h3, 8'h00), 0);
    // Timer 1 toggle match with status flag; its count is parked now
    xfer(1'b0, ra(1, DGT_COUNT_OFS), 32'h0, c1, e);
    wr(ra(1, DGT_REF_OFS), c1 + 32'h20);
    wr(ra(1, DGT_CTRL_OFS), cv(2'b01, 5'he, 2'h0, 8'h00));
    n = 0;
    while (w1 !== 1'b0 && n < 200)
    begin
      @(posedge clock);
      n++;
    end
    chk("wave1 toggle", {31'h0, w1}, 32'h0);
    xfer(1'b0, DGT_STAT_OFS, 32'h0, d, e);
    chk("cmp1 status", d & 32'h8, 32'h8);
    print_verdict();
  end
endmodule : dual_general_purpose_timer_tb_top
`default_nettype wire
